// [sbsw_pkg.sv]
// Package of constants and carriers for the sub-band output switch
package sbsw_pkg;
  localparam int NUM_SUB     = 18;
  localparam int SEL_W       = 5;
  localparam int SAMP_W      = 8;
  localparam int NUM_GATES   = 4;
  localparam int SYN_W       = 32;
  localparam int FIFO_DEPTH  = 32;
  localparam int CLK_MHZ     = 200;
  localparam int EPOCH_MS    = 10;
  localparam int EPOCH_CYC   = EPOCH_MS * 1000 * CLK_MHZ;
  localparam int ID_W        = 16;
  localparam int PC_ACC_W    = 24;
  localparam int STAT_W      = 32;
  localparam logic [SEL_W-1:0] SEL_RST = 5'h00;
  localparam logic [ID_W-1:0]  ID_RST  = 16'h0000;

  // One sample travelling the output path
  typedef struct packed {
    logic              valid;
    logic              is_id;
    logic [SAMP_W-1:0] data;
  } sbsw_samp_s;

  // One gate description
  typedef struct packed {
    logic [SYN_W-1:0] start;
    logic [SYN_W-1:0] len;
  } sbsw_gate_s;

  // Point-slope synthesizer coefficients
  typedef struct packed {
    logic [SYN_W-1:0] point;
    logic [SYN_W-1:0] slope;
  } sbsw_coef_s;
endpackage

// [sbsw_fifo.sv]
// Parameterised valid/ready FIFO with registered read data
`timescale 1ns/1ps
module sbsw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             next_out_valid;
  logic             push;
  logic             pop;
  logic             load;

  // Handshakes; output register reloads when empty or consumed
  always_comb begin
    push           = in_valid_i && in_ready_o;
    load           = (count != '0) && (!out_valid_o || out_ready_i);
    pop            = load;
    next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count     = count + (AW+1)'(push) - (AW+1)'(pop);
    next_out_valid = load ? 1'b1 : (out_ready_i ? 1'b0 : out_valid_o);
  end

  // Pointer and flag registers
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      out_valid_o <= 1'b0;
      in_ready_o  <= 1'b0;
    end else begin
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      count       <= next_count;
      out_valid_o <= next_out_valid;
      in_ready_o  <= (next_count < (AW+1)'(DEPTH - 1));
    end
  end

  // Storage and registered read data
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
    if (!nrst_i) begin
      out_data_o <= '0;
    end else if (load) begin
      out_data_o <= mem[rd_ptr];
    end
  end
endmodule

// [sbsw_top.sv]
// Sub-band output crossbar, pulsar gating, statistics, id insertion and timing
`timescale 1ns/1ps
// Overview of operation
// [RQ1] Each of 18 output slots selects any of 18 sub-band filter outputs.
// [RQ2] Per sub-band, count samples per quantizer state and accumulate power. Code keeps one non-negative count and one power sum for all slots.
// [RQ3] One phase-cal extractor per baseband, time-shared across sub-bands. Code serves only the one sub-band chosen by pcal_sel.
// [RQ4] Identification words are inserted into the output streams.
// [RQ5] Timer and gates use 32-bit point-slope synthesizers, reloaded per 10 ms.
// [RQ6] Several independent gates with own start and length, locked to timer.
// [RQ7] Timer wrap feeds the dump-command stream generator.
// [RQ8] Dump, delay, phase streams, clock and time code aligned to time code.
// [RQ9] Only the master-slot board drives timing and model streams downstream.
// [RQ10] In binning mode, dumps follow timer epoch; coefficients load on 10 ms.
// [RQ11] External blanking input clears data-valid of output samples.
// [RQ12] Blanking input passes a two-flop synchroniser before use.
// [RQ13] Routing, gates and coefficients shadowed, applied at 10 ms epoch.
module sbsw_top (
  // Clock and reset
  input  wire logic                                   sys_clk_i,
  input  wire logic                                   nrst_i,
  // Sub-band filter outputs
  input  wire logic [sbsw_pkg::NUM_SUB-1:0][sbsw_pkg::SAMP_W-1:0] sub_data_i,
  input  wire logic                                   sub_valid_i,
  // Configuration; routing, gates and timer coefficients go through shadow
  input  wire logic [sbsw_pkg::NUM_SUB-1:0][sbsw_pkg::SEL_W-1:0] route_sel_i,
  input  wire sbsw_pkg::sbsw_gate_s [sbsw_pkg::NUM_GATES-1:0]    gate_cfg_i,
  input  wire logic [sbsw_pkg::NUM_SUB-1:0][1:0]      gate_map_i,
  input  wire sbsw_pkg::sbsw_coef_s                   timer_coef_i,
  input  wire logic                                   cfg_load_i,
  input  wire logic [sbsw_pkg::ID_W-1:0]              id_word_i,
  input  wire logic                                   id_en_i,
  input  wire logic                                   bin_mode_i,
  input  wire logic [sbsw_pkg::SEL_W-1:0]             pcal_sel_i,
  input  wire logic                                   master_slot_i,
  // Time code and model inputs
  input  wire logic                                   time_code_i,
  input  wire logic                                   epoch_i,
  input  wire logic                                   dump_req_i,
  input  wire logic                                   delay_bit_i,
  input  wire logic                                   phase_bit_i,
  input  wire logic                                   blank_n_i,
  // Output stream
  output logic                                        out_valid_o,
  output logic [sbsw_pkg::SEL_W-1:0]                  out_slot_o,
  output sbsw_pkg::sbsw_samp_s                        out_samp_o,
  input  wire logic                                   out_ready_i,
  output logic                                        in_ready_o,
  // Timing streams
  output logic                                        dump_command_stream_o,
  output logic                                        delay_model_stream_o,
  output logic                                        phase_model_stream_o,
  output logic                                        system_time_code_o,
  output logic                                        link_clk_o,
  // Statistics and phase-cal
  output logic [sbsw_pkg::STAT_W-1:0]                 stat_hi_cnt_o,
  output logic [sbsw_pkg::STAT_W-1:0]                 stat_pwr_o,
  output logic [sbsw_pkg::PC_ACC_W-1:0]               pcal_acc_o
);
  localparam int N = sbsw_pkg::NUM_SUB;
  localparam int G = sbsw_pkg::NUM_GATES;

  ////////////////////////////////////////////////////////////////////////
  // Blanking synchroniser and epoch-applied shadow registers
  logic                                         blank_n_s1;
  logic                                         blank_n_s2;
  logic [N-1:0][sbsw_pkg::SEL_W-1:0]            route_sh;
  logic [N-1:0][sbsw_pkg::SEL_W-1:0]            route_act;
  sbsw_pkg::sbsw_gate_s [G-1:0]                 gate_sh;
  sbsw_pkg::sbsw_gate_s [G-1:0]                 gate_act;
  sbsw_pkg::sbsw_coef_s                         coef_sh;
  sbsw_pkg::sbsw_coef_s                         coef_act;
  logic [N-1:0][sbsw_pkg::SEL_W-1:0]            next_route_sh;
  logic [N-1:0][sbsw_pkg::SEL_W-1:0]            next_route_act;
  sbsw_pkg::sbsw_gate_s [G-1:0]                 next_gate_sh;
  sbsw_pkg::sbsw_gate_s [G-1:0]                 next_gate_act;
  sbsw_pkg::sbsw_coef_s                         next_coef_sh;
  sbsw_pkg::sbsw_coef_s                         next_coef_act;

  // Software writes land in shadow, go live together on the epoch
  always_comb begin
    next_route_sh  = cfg_load_i ? route_sel_i : route_sh;   // RQ13
    next_gate_sh   = cfg_load_i ? gate_cfg_i : gate_sh;
    next_coef_sh   = cfg_load_i ? timer_coef_i : coef_sh;
    next_route_act = epoch_i ? route_sh : route_act;         // RQ13
    next_gate_act  = epoch_i ? gate_sh : gate_act;
    next_coef_act  = epoch_i ? coef_sh : coef_act;           // RQ5 RQ10
  end

  // Shadow, active and synchroniser registers
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      blank_n_s1 <= 1'b1;
      blank_n_s2 <= 1'b1;
      route_sh   <= '0;
      route_act  <= '0;
      gate_sh    <= '0;
      gate_act   <= '0;
      coef_sh    <= '0;
      coef_act   <= '0;
    end else begin
      blank_n_s1 <= blank_n_i;   // RQ12
      blank_n_s2 <= blank_n_s1;  // RQ12
      route_sh   <= next_route_sh;
      route_act  <= next_route_act;
      gate_sh    <= next_gate_sh;
      gate_act   <= next_gate_act;
      coef_sh    <= next_coef_sh;
      coef_act   <= next_coef_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulsar timer: point-slope synthesizer, phase restarted on epoch
  logic [sbsw_pkg::SYN_W-1:0] tmr_rate;
  logic [sbsw_pkg::SYN_W-1:0] tmr_phase;
  logic                       tmr_wrap;
  logic [sbsw_pkg::SYN_W-1:0] next_tmr_rate;
  logic [sbsw_pkg::SYN_W-1:0] next_tmr_phase;
  logic                       next_tmr_wrap;
  logic [sbsw_pkg::SYN_W:0]   tmr_sum;

  // Rate ramps by slope; phase accumulates rate, wrap marks pulsar epoch
  always_comb begin
    tmr_sum        = {1'b0, tmr_phase} + {1'b0, tmr_rate};
    next_tmr_rate  = epoch_i ? coef_sh.point : tmr_rate + coef_act.slope;  // RQ5
    next_tmr_phase = epoch_i ? '0 : tmr_sum[sbsw_pkg::SYN_W-1:0];          // RQ10
    next_tmr_wrap  = !epoch_i && tmr_sum[sbsw_pkg::SYN_W];                 // RQ7
  end

  // Timer registers
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      tmr_rate  <= '0;
      tmr_phase <= '0;
      tmr_wrap  <= 1'b0;
    end else begin
      tmr_rate  <= next_tmr_rate;
      tmr_phase <= next_tmr_phase;
      tmr_wrap  <= next_tmr_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gates: window on timer phase, one per gate
  logic [G-1:0] gate_on;
  genvar gi;
  generate
    for (gi = 0; gi < G; gi++) begin : g_gate
      logic [sbsw_pkg::SYN_W-1:0] off;
      assign off         = tmr_phase - gate_act[gi].start;
      assign gate_on[gi] = (off < gate_act[gi].len);  // RQ6
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Crossbar with gating, round-robin slot scanning into the FIFO
  logic [sbsw_pkg::SEL_W-1:0] slot;
  logic [sbsw_pkg::SEL_W-1:0] next_slot;
  logic                       id_pend;
  logic                       next_id_pend;
  logic [sbsw_pkg::SEL_W-1:0] src;
  sbsw_pkg::sbsw_samp_s       fifo_in;
  logic                       fifo_rdy;
  logic [sbsw_pkg::SEL_W+$bits(sbsw_pkg::sbsw_samp_s)-1:0] fifo_out;
  logic                       fifo_vld;

  // Select source, apply gate and blanking, insert id word on epoch
  always_comb begin
    src          = route_act[slot];                                   // RQ1
    fifo_in.is_id = id_pend;                                          // RQ4
    fifo_in.data = id_pend ? id_word_i[sbsw_pkg::SAMP_W-1:0]
                           : sub_data_i[src];
    fifo_in.valid = !id_pend && sub_valid_i && blank_n_s2             // RQ11
                    && gate_on[gate_map_i[slot]];                     // RQ6
    next_slot    = slot;
    next_id_pend = id_pend || (epoch_i && id_en_i);
    if (fifo_rdy) begin
      next_slot = (slot == sbsw_pkg::SEL_W'(N - 1)) ? '0 : slot + 1'b1;
      if (slot == sbsw_pkg::SEL_W'(N - 1)) begin
        next_id_pend = epoch_i && id_en_i;
      end
    end
  end

  // Scan registers
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      slot    <= '0;
      id_pend <= 1'b0;
    end else begin
      slot    <= next_slot;
      id_pend <= next_id_pend;
    end
  end

  sbsw_fifo #(
    .WIDTH (sbsw_pkg::SEL_W + $bits(sbsw_pkg::sbsw_samp_s)),
    .DEPTH (sbsw_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (1'b1),
    .in_data_i   ({slot, fifo_in}),
    .in_ready_o  (fifo_rdy),
    .out_valid_o (fifo_vld),
    .out_data_o  (fifo_out),
    .out_ready_i (out_ready_i)
  );

  // FIFO outputs are registered inside the FIFO
  assign out_valid_o = fifo_vld;
  assign out_slot_o  = fifo_out[sbsw_pkg::SEL_W+$bits(sbsw_pkg::sbsw_samp_s)-1 -: sbsw_pkg::SEL_W];
  assign out_samp_o  = fifo_out[$bits(sbsw_pkg::sbsw_samp_s)-1:0];
  assign in_ready_o  = fifo_rdy;

  ////////////////////////////////////////////////////////////////////////
  // Requantizer statistics and shared phase-cal extractor
  logic [sbsw_pkg::STAT_W-1:0]   next_hi_cnt;
  logic [sbsw_pkg::STAT_W-1:0]   next_pwr;
  logic [sbsw_pkg::PC_ACC_W-1:0] next_pcal;
  logic signed [sbsw_pkg::SAMP_W-1:0] cur;

  // Count high-state samples, sum squares, correlate chosen sub-band
  always_comb begin
    cur         = sub_data_i[src];
    next_hi_cnt = stat_hi_cnt_o + sbsw_pkg::STAT_W'(cur[sbsw_pkg::SAMP_W-1] == 1'b0); // RQ2
    next_pwr    = stat_pwr_o + sbsw_pkg::STAT_W'(cur * cur);                          // RQ2
    next_pcal   = pcal_acc_o;
    if (src == pcal_sel_i) begin
      next_pcal = tmr_phase[sbsw_pkg::SYN_W-1] ? pcal_acc_o - sbsw_pkg::PC_ACC_W'(cur)
                                               : pcal_acc_o + sbsw_pkg::PC_ACC_W'(cur); // RQ3
    end
    if (epoch_i) begin
      next_hi_cnt = '0;
      next_pwr    = '0;
      next_pcal   = '0;
    end
  end

  // Statistics registers
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      stat_hi_cnt_o <= '0;
      stat_pwr_o    <= '0;
      pcal_acc_o    <= '0;
    end else begin
      stat_hi_cnt_o <= next_hi_cnt;
      stat_pwr_o    <= next_pwr;
      pcal_acc_o    <= next_pcal;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timing streams, retimed together and gated by master slot
  logic next_dump;
  logic next_lclk;

  // Dump follows timer wrap in binning mode, else the request
  always_comb begin
    next_dump = bin_mode_i ? tmr_wrap : dump_req_i;  // RQ10 RQ7
    next_lclk = !link_clk_o;
  end

  // Streams register on the same edge as the time code
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      dump_command_stream_o <= 1'b0;
      delay_model_stream_o  <= 1'b0;
      phase_model_stream_o  <= 1'b0;
      system_time_code_o    <= 1'b0;
      link_clk_o            <= 1'b0;
    end else begin
      dump_command_stream_o <= master_slot_i && next_dump;    // RQ8 RQ9
      delay_model_stream_o  <= master_slot_i && delay_bit_i;  // RQ8 RQ9
      phase_model_stream_o  <= master_slot_i && phase_bit_i;  // RQ8 RQ9
      system_time_code_o    <= master_slot_i && time_code_i;  // RQ8 RQ9
      link_clk_o            <= master_slot_i && next_lclk;    // RQ8
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_blank;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !blank_n_s2 |-> !fifo_in.valid;
  endproperty
  a_blank: assert property (p_blank) else $error("valid while blanked"); // RQ11

  property p_sync;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $fell(blank_n_i) |-> ##2 !blank_n_s2;
  endproperty
  a_sync: assert property (p_sync) else $error("sync latency wrong"); // RQ12

  property p_apply;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      epoch_i |=> route_act == $past(route_sh);
  endproperty
  a_apply: assert property (p_apply) else $error("route not applied"); // RQ13

  property p_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !epoch_i |=> $stable(coef_act);
  endproperty
  a_hold: assert property (p_hold) else $error("coef changed off epoch"); // RQ10

  property p_master;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !master_slot_i |=> !dump_command_stream_o && !system_time_code_o;
  endproperty
  a_master: assert property (p_master) else $error("slave drove stream"); // RQ9

  property p_bin;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      bin_mode_i && master_slot_i && tmr_wrap |=> dump_command_stream_o;
  endproperty
  a_bin: assert property (p_bin) else $error("dump missed timer"); // RQ7

  property p_xbar;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !id_pend |-> fifo_in.data == sub_data_i[route_act[slot]];
  endproperty
  a_xbar: assert property (p_xbar) else $error("crossbar wrong"); // RQ1

  property p_phase0;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      epoch_i |=> tmr_phase == '0 && !tmr_wrap;
  endproperty
  a_phase0: assert property (p_phase0) else $error("timer not restarted"); // RQ5
endmodule

// [sbsw_rc_model.sv]
// Downstream receiver model: takes output words at a chosen pace
`timescale 1ns/1ps
module sbsw_rc_model (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 nrst_i,
  // Word stream from the switch
  input  wire logic                 out_valid_i,
  input  wire logic [4:0]           out_slot_i,
  input  wire sbsw_pkg::sbsw_samp_s out_samp_i,
  output logic                      out_ready_o,
  // Pace control and hold check
  input  wire logic [1:0]           mode_i,
  output logic                      hold_bad_o
);
  logic [15:0]          lf;
  logic                 pend;
  sbsw_pkg::sbsw_samp_s last;
  logic [4:0]           last_slot;

  // Pace 0 stalls, 1 takes every word, 2 takes at random
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      lf <= 16'h005C;
      out_ready_o <= 1'b0;
      pend <= 1'b0;
      hold_bad_o <= 1'b0;
    end else begin
      lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      out_ready_o <= (mode_i == 2'h1) || (mode_i == 2'h2 && lf[0]);
      // A word offered but not taken must stand unchanged
      hold_bad_o <= pend && ({out_valid_i, out_samp_i, out_slot_i} !== {1'b1, last, last_slot});
      pend <= out_valid_i && !out_ready_o;
    end
    last <= out_samp_i;
    last_slot <= out_slot_i;
  end
endmodule

// [tb_top.sv]
// Self-checking bench for the sub-band output switch
`timescale 1ns/1ps
module tb_top;
  logic                                               sys_clk;
  logic                                               nrst;
  logic [sbsw_pkg::NUM_SUB-1:0][sbsw_pkg::SAMP_W-1:0] sub_data;
  logic [sbsw_pkg::NUM_SUB-1:0][sbsw_pkg::SEL_W-1:0]  route_sel;
  sbsw_pkg::sbsw_gate_s [sbsw_pkg::NUM_GATES-1:0]     gate_cfg;
  logic [sbsw_pkg::NUM_SUB-1:0][1:0]                  gate_map;
  sbsw_pkg::sbsw_coef_s                               timer_coef;
  sbsw_pkg::sbsw_samp_s                               out_samp;
  logic cfg_load, id_en, bin_mode, master, time_code, epoch, dump_req, delay_bit, phase_bit;
  logic blank_n, out_valid, out_ready, in_ready, dump_o, delay_o, phase_o, tc_o, link_o, hold_bad;
  logic [4:0]                                         pcal_sel, out_slot;
  logic [31:0]                                        hi_cnt, pwr;
  logic [23:0]                                        pcal;
  logic [1:0]                                         mode;
  logic [15:0]                                        lf, lf2;
  logic [7:0]                                         od [18], nw [18];
  bit                                                 sw [18];
  bit                                                 id_allow, hold_old, chk_str;
  int                                                 n_errors, tests_run, exp_slot, exp_valid;
  int                                                 n_id;
  // Reference model state: timer, scan slot, routing and statistics
  logic [31:0]                                        m_rate, m_phase, m_slope, m_hi, m_pwr;
  logic [32:0]                                        m_sum;
  logic [23:0]                                        m_pcal;
  logic signed [7:0]                                  m_cur;
  logic [4:0]                                         m_slot, m_rsh [18], m_ract [18];
  sbsw_pkg::sbsw_coef_s                               m_sh;
  bit                                                 m_wrap, m_lclk, exp_dump;

  sbsw_top i_sbsw_top (.sys_clk_i(sys_clk), .nrst_i(nrst), .sub_data_i(sub_data),
    .sub_valid_i(1'b1), .route_sel_i(route_sel), .gate_cfg_i(gate_cfg), .gate_map_i(gate_map),
    .timer_coef_i(timer_coef), .cfg_load_i(cfg_load), .id_word_i(16'hA55A), .id_en_i(id_en),
    .bin_mode_i(bin_mode), .pcal_sel_i(pcal_sel), .master_slot_i(master), .time_code_i(time_code),
    .epoch_i(epoch), .dump_req_i(dump_req), .delay_bit_i(delay_bit), .phase_bit_i(phase_bit),
    .blank_n_i(blank_n), .out_valid_o(out_valid), .out_slot_o(out_slot), .out_samp_o(out_samp),
    .out_ready_i(out_ready), .in_ready_o(in_ready), .dump_command_stream_o(dump_o),
    .delay_model_stream_o(delay_o), .phase_model_stream_o(phase_o), .system_time_code_o(tc_o),
    .link_clk_o(link_o), .stat_hi_cnt_o(hi_cnt), .stat_pwr_o(pwr), .pcal_acc_o(pcal));

  sbsw_rc_model i_sbsw_rc_model (.sys_clk_i(sys_clk), .nrst_i(nrst), .out_valid_i(out_valid),
    .out_slot_i(out_slot), .out_samp_i(out_samp), .out_ready_o(out_ready), .mode_i(mode),
    .hold_bad_o(hold_bad));

  function automatic logic [15:0] lfsr_f(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // New routing and timer coefficients go to shadow, then take effect at the epoch; other settings apply at once
  task automatic cfg(input int off, input bit id);
    for (int s = 0; s < 18; s++) begin
      route_sel[s] = 5'((s * 5 + off) % 18);
      od[s] = nw[s];
      nw[s] = sub_data[(s * 5 + off) % 18];
      sw[s] = 1'b0;
      gate_map[s] = 2'(lf2 >> (s % 8));
    end
    lf2 = lfsr_f(lf2);
    pcal_sel = 5'(lf2 % 18);
    bin_mode = lf2[4];
    timer_coef = '{point: {lf2[3:0] | 4'h1, 28'h0000000}, slope: 32'({lf2[7:1], 1'b0})};
    id_en = id;
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
    hold_old = 1'b1;
    id_allow = id_allow | id;
    cyc(100);
    epoch = 1'b1;
    hold_old = 1'b0;
    cyc(1);
    epoch = 1'b0;
  endtask

  // Clock at 200 MHz
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Model of timer, slot scan, shadowed routing and statistics, one step per edge
  always @(posedge sys_clk) begin
    if (nrst !== 1'b1) begin
      {m_rate, m_phase, m_slope, m_hi, m_pwr, m_pcal, m_slot} = '0;
      {m_wrap, m_lclk, exp_dump} = '0;
      m_sh = '0;
      for (int i = 0; i < 18; i++) begin
        m_rsh[i] = '0;
        m_ract[i] = '0;
      end
    end else begin
      exp_dump = master && (bin_mode ? m_wrap : dump_req);
      m_lclk = master && !m_lclk;
      m_cur = sub_data[m_ract[m_slot]];
      if (epoch) begin
        {m_hi, m_pwr, m_pcal} = '0;
      end else begin
        m_hi = m_hi + 32'(!m_cur[7]);
        m_pwr = m_pwr + 32'(m_cur * m_cur);
        if (m_ract[m_slot] == pcal_sel) begin
          m_pcal = m_phase[31] ? m_pcal - 24'(m_cur) : m_pcal + 24'(m_cur);
        end
      end
      if (epoch) begin
        m_rate = m_sh.point;
        m_phase = '0;
        m_wrap = 1'b0;
        m_slope = m_sh.slope;
      end else begin
        m_sum = {1'b0, m_phase} + {1'b0, m_rate};
        m_wrap = m_sum[32];
        m_phase = m_sum[31:0];
        m_rate = m_rate + m_slope;
      end
      if (in_ready === 1'b1) begin
        m_slot = (m_slot == 5'h11) ? 5'h00 : m_slot + 5'h01;
      end
      for (int i = 0; i < 18; i++) begin
        if (epoch) m_ract[i] = m_rsh[i];
        if (cfg_load) m_rsh[i] = route_sel[i];
      end
      if (cfg_load) m_sh = timer_coef;
    end
  end

  // Every accepted word is compared with the slot and route model
  always @(posedge sys_clk) begin
    if (nrst === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
      chk(32'(out_slot), 32'(exp_slot), "slot order");
      if (out_samp.is_id === 1'b1) begin
        chk({id_allow, out_samp.valid, out_samp.data}, 10'h25A, "id word");
        n_id++;
      end else if (hold_old) begin
        chk(32'(out_samp.data), 32'(od[exp_slot]), "early route");
      end else if (out_samp.data === nw[exp_slot]) begin
        sw[exp_slot] = 1'b1;
      end else begin
        chk(32'(out_samp.data), 32'(sw[exp_slot] ? nw[exp_slot] : od[exp_slot]), "route");
      end
      if (out_samp.is_id !== 1'b1 && exp_valid != 2) begin
        chk(32'(out_samp.valid), 32'(exp_valid), "data valid");
      end
      exp_slot = (exp_slot + 1) % 18;
    end
  end

  // Serial inputs change each cycle; streams follow one cycle later
  always @(negedge sys_clk) begin
    if (chk_str) begin
      chk(32'(delay_o), 32'(delay_bit & master), "delay stream");
      chk(32'(phase_o), 32'(phase_bit & master), "phase stream");
      chk(32'(tc_o), 32'(time_code & master), "time code");
      if (!master) chk(32'({dump_o, link_o}), 32'h0, "idle streams");
      chk(32'(hold_bad), 32'h0, "word held");
      chk(32'({dump_o, link_o}), 32'({exp_dump, m_lclk}), "dump and clock");
      chk(hi_cnt, m_hi, "state count");
      chk(pwr, m_pwr, "power");
      chk(32'(pcal), 32'(m_pcal), "phase-cal");
    end
    lf = lfsr_f(lf);
    delay_bit = lf[0];
    phase_bit = lf[3];
    time_code = lf[5];
    dump_req = lf[7];
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    conclude();
  end

  // Main sequence
  initial begin
    lf = 16'h005C;
    lf2 = 16'h005C;
    {nrst, cfg_load, id_en, bin_mode, master, epoch, chk_str, id_allow, hold_old} = '0;
    {time_code, dump_req, delay_bit, phase_bit} = '0;
    blank_n = 1'b1;
    mode = 2'h2;
    pcal_sel = 5'h00;
    gate_map = '0;
    timer_coef = '0;
    exp_valid = 2;
    for (int i = 0; i < 18; i++) begin
      sub_data[i] = 8'(8'h11 + i * 7);
      route_sel[i] = sbsw_pkg::SEL_RST;
      gate_cfg[i % 4] = '{start: 32'h0, len: 32'hFFFF_FFFF};
    end
    for (int i = 0; i < 18; i++) begin
      nw[i] = sub_data[sbsw_pkg::SEL_RST];
    end
    cyc(16);
    chk(32'({out_valid, dump_o, link_o, tc_o}), 32'h0, "reset outputs");
    chk(pwr, 32'h0, "reset power");
    nrst = 1'b1;
    cyc(3);
    chk_str = 1'b1;
    cfg(3, 1'b0);
    cyc(150);
    exp_valid = 1;
    cyc(300);
    cfg(4, 1'b0);
    cyc(400);
    mode = 2'h0;
    cyc(60);
    chk(32'({in_ready, out_valid}), 32'h1, "fifo full");
    mode = 2'h1;
    cyc(100);
    chk(32'(in_ready), 32'h1, "fifo drained");
    blank_n = 1'b0;
    exp_valid = 2;
    cyc(40);
    exp_valid = 0;
    cyc(100);
    blank_n = 1'b1;
    exp_valid = 2;
    cyc(40);
    exp_valid = 1;
    mode = 2'h2;
    cfg(7, 1'b1);
    cyc(300);
    chk(32'(n_id > 0), 32'h1, "id words seen");
    cfg(7, 1'b0);
    cyc(150);
    id_allow = 1'b0;
    cyc(200);
    chk_str = 1'b0;
    master = 1'b1;
    bin_mode = 1'b0;
    cyc(3);
    chk_str = 1'b1;
    cyc(100);
    bin_mode = 1'b1;
    cyc(100);
    chk_str = 1'b0;
    master = 1'b0;
    cyc(3);
    chk_str = 1'b1;
    cyc(50);
    conclude();
  end
endmodule
